/* gcu_pin_setup.v */
// Pin setup block: mode, drive level and special functions of seven pins.
// Assumes a same-clock register port master and asynchronous pin inputs.
//
// How it works
// - Setup A holds seven two-bit mode fields, pin 6 at 13:12, 15:14 zero.
// - Mode 00 ratiometric, 01 absolute analog, 10 digital in, 11 digital out.
// - A digital-output pin is driven low for drive bit 0, high for 1.
// - Drive bits at setup B 6:0 count only when the pin mode is 11.
// - With bit 9 set, pin 2 rising edge starts converter 1 in normal mode.
// - The pin 2 conversion trigger works only while pin 2 mode is 10.
// - With bit 8 set, any pin 0 edge wakes the device from sleep.
// - The pin 0 wake-up works only while pin 0 mode is 10.
// - With bit 7 set and pin 0 high as input, the fault pin asserts.
// - The pin 0 fault routing works only while pin 0 mode is 10.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "gcu_map.vh"
module gcu_pin_setup #(
    parameter PINS = 7
) (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   reset_n,
    // Register port
    input  wire [`GCU_ADDR_W-1:0] reg_addr,
    input  wire [15:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [15:0]            reg_rdata,
    // Pins
    input  wire [PINS-1:0]        pin_in,
    output reg  [PINS-1:0]        pin_out,
    output reg  [PINS-1:0]        pin_oe,
    // Device state and events
    input  wire                   normal_mode,
    input  wire                   sleep_mode,
    output reg                    conv_start,
    output reg                    wake_req,
    output reg                    fault_pin,
    output reg                    irq
);
    reg  [15:0]           pin_setup_a_reg;
    reg  [15:0]           pin_setup_b_reg;
    reg  [`GCU_IRQ_W-1:0] irq_status_reg;
    reg  [`GCU_IRQ_W-1:0] irq_mask_reg;
    reg  [PINS-1:0]       pin_prev_reg;
    reg  [`GCU_IRQ_W-1:0] irq_status_next;
    reg  [PINS-1:0]       out_mask;
    reg  [PINS-1:0]       in_mask;
    wire [PINS-1:0]       pin_sync;
    wire                  trig_evt;
    wire                  wake_evt;
    wire                  alarm_lvl;

    // Next values and write decode.
    reg  [15:0]           pin_setup_a_next;
    reg  [15:0]           pin_setup_b_next;
    reg  [`GCU_IRQ_W-1:0] irq_mask_next;
    reg  [15:0]           rdata_next;
    reg  [PINS-1:0]       pin_oe_next;
    reg  [PINS-1:0]       pin_out_next;
    reg                   irq_next;
    wire                  wr_setup_a;
    wire                  wr_setup_b;
    wire                  wr_irq_status;
    wire                  wr_irq_mask;
    integer               i;

    // Returns the two-bit mode field of one pin.
    function [1:0] pin_mode_field;
        input [15:0]  setup;
        input integer idx;
        begin
            pin_mode_field = setup[2*idx +: 2];
        end
    endfunction

    // Returns one when a strobe is aimed at the given register.
    function addr_hit;
        input                   strobe;
        input [`GCU_ADDR_W-1:0] addr;
        input [`GCU_ADDR_W-1:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    gcu_pin_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .pin_async (pin_in),
        .pin_sync  (pin_sync)
    );

    // Per-pin mode decode.
    always @* begin
        out_mask = {PINS{1'b0}};
        in_mask  = {PINS{1'b0}};
        for (i = 0; i < PINS; i = i + 1) begin
            out_mask[i] = (pin_mode_field(pin_setup_a_reg, i)
                           == `GCU_MODE_DOUT);
            in_mask[i]  = (pin_mode_field(pin_setup_a_reg, i)
                           == `GCU_MODE_DIN);
        end
    end

    assign trig_evt  = pin_setup_b_reg[`GCU_TRIG_BIT] && in_mask[2]
                       && pin_sync[2] && !pin_prev_reg[2]
                       && normal_mode;
    assign wake_evt  = pin_setup_b_reg[`GCU_WAKE_BIT] && in_mask[0]
                       && (pin_sync[0] != pin_prev_reg[0])
                       && sleep_mode;
    assign alarm_lvl = pin_setup_b_reg[`GCU_ALARM_BIT] && in_mask[0]
                       && pin_sync[0];

    // Status bits: a new event wins over a write-one clear.
    always @* begin
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~reg_wdata[`GCU_IRQ_W-1:0];
        end
        irq_status_next[`GCU_IRQ_TRIG]  = irq_status_next[`GCU_IRQ_TRIG]
                                          | trig_evt;
        irq_status_next[`GCU_IRQ_WAKE]  = irq_status_next[`GCU_IRQ_WAKE]
                                          | wake_evt;
        irq_status_next[`GCU_IRQ_ALARM] = irq_status_next[`GCU_IRQ_ALARM]
                                          | alarm_lvl;
    end

    // Write decode.
    assign wr_setup_a    = addr_hit(reg_wr, reg_addr, `GCU_PIN_SETUP_A);
    assign wr_setup_b    = addr_hit(reg_wr, reg_addr, `GCU_PIN_SETUP_B);
    assign wr_irq_status = addr_hit(reg_wr, reg_addr, `GCU_IRQ_STATUS);
    assign wr_irq_mask   = addr_hit(reg_wr, reg_addr, `GCU_IRQ_MASK);

    // Setup A takes the mode fields; bits 15:14 stay zero.
    always @* begin
        pin_setup_a_next = pin_setup_a_reg;
        if (wr_setup_a) begin
            pin_setup_a_next = reg_wdata & `GCU_SETUP_A_MASK;
        end
    end

    // Setup B takes drive levels and enables; bits 15:10 stay zero.
    always @* begin
        pin_setup_b_next = pin_setup_b_reg;
        if (wr_setup_b) begin
            pin_setup_b_next = reg_wdata & `GCU_SETUP_B_MASK;
        end
    end

    // The interrupt mask takes the low status-wide bits.
    always @* begin
        irq_mask_next = irq_mask_reg;
        if (wr_irq_mask) begin
            irq_mask_next = reg_wdata[`GCU_IRQ_W-1:0];
        end
    end

    // Read data stands in the cycle after the strobe and is zero otherwise.
    always @* begin
        rdata_next = 16'h0000;
        if (addr_hit(reg_rd, reg_addr, `GCU_PIN_SETUP_A)) begin
            rdata_next = pin_setup_a_reg;
        end else if (addr_hit(reg_rd, reg_addr, `GCU_PIN_SETUP_B)) begin
            rdata_next = pin_setup_b_reg;
        end else if (addr_hit(reg_rd, reg_addr, `GCU_IRQ_STATUS)) begin
            rdata_next = {{(16-`GCU_IRQ_W){1'b0}}, irq_status_reg};
        end else if (addr_hit(reg_rd, reg_addr, `GCU_IRQ_MASK)) begin
            rdata_next = {{(16-`GCU_IRQ_W){1'b0}}, irq_mask_reg};
        end else if (addr_hit(reg_rd, reg_addr, `GCU_PIN_LEVEL)) begin
            rdata_next = {{(16-PINS){1'b0}}, pin_sync};
        end
    end

    // Only digital-output pins have their driver enabled.
    always @* begin
        pin_oe_next = out_mask;
    end

    // Only digital-output pins carry their drive level.
    always @* begin
        pin_out_next = pin_setup_b_reg[`GCU_DRIVE_LSB +: PINS]
                       & out_mask;
    end

    // The interrupt follows status and mask as they will stand.
    always @* begin
        irq_next = |(irq_status_next & irq_mask_next);
    end

    // The setup A register.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_setup_a_reg <= `GCU_SETUP_A_RESET;
        end else begin
            pin_setup_a_reg <= pin_setup_a_next;
        end
    end

    // The setup B register.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_setup_b_reg <= `GCU_SETUP_B_RESET;
        end else begin
            pin_setup_b_reg <= pin_setup_b_next;
        end
    end

    // The sticky interrupt status.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_reg <= {`GCU_IRQ_W{1'b0}};
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // The interrupt mask.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_reg <= {`GCU_IRQ_W{1'b0}};
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // The previous pin levels for edge detection.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_prev_reg <= {PINS{1'b0}};
        end else begin
            pin_prev_reg <= pin_sync;
        end
    end

    // The read data.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // The pin output enables.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_oe <= {PINS{1'b0}};
        end else begin
            pin_oe <= pin_oe_next;
        end
    end

    // The pin output levels.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out <= {PINS{1'b0}};
        end else begin
            pin_out <= pin_out_next;
        end
    end

    // The conversion start pulse.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= trig_evt;
        end
    end

    // The wake-up pulse.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wake_evt;
        end
    end

    // The fault pin level.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_pin <= 1'b0;
        end else begin
            fault_pin <= alarm_lvl;
        end
    end

    // The interrupt output.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end
endmodule

/* gcu_map.vh */
// Register offsets, field positions, reset values and timing for the pin setup.
// Included by the pin setup block and its pin sampler.
`ifndef GCU_MAP_VH
`define GCU_MAP_VH
`define GCU_ADDR_W          8
`define GCU_PIN_SETUP_A     8'h1D
`define GCU_PIN_SETUP_B     8'h1E
`define GCU_IRQ_STATUS      8'h30
`define GCU_IRQ_MASK        8'h31
`define GCU_PIN_LEVEL       8'h32
`define GCU_SETUP_A_RESET   16'h0000
`define GCU_SETUP_B_RESET   16'h0000
`define GCU_SETUP_A_MASK    16'h3FFF
`define GCU_SETUP_B_MASK    16'h03FF
`define GCU_DRIVE_LSB       0
`define GCU_ALARM_BIT       7
`define GCU_WAKE_BIT        8
`define GCU_TRIG_BIT        9
`define GCU_MODE_RATIO      2'b00
`define GCU_MODE_ABS        2'b01
`define GCU_MODE_DIN        2'b10
`define GCU_MODE_DOUT       2'b11
`define GCU_IRQ_TRIG        0
`define GCU_IRQ_WAKE        1
`define GCU_IRQ_ALARM       2
`define GCU_IRQ_W           3
`define GCU_SYNC_STAGES     2
`endif

/* gcu_pin_sync.v */
// Two-flop synchroniser for the general-purpose pin inputs.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/10ps
`include "gcu_map.vh"
module gcu_pin_sync #(
    parameter WIDTH = 7
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             reset_n,
    // Pins
    input  wire [WIDTH-1:0] pin_async,
    output reg  [WIDTH-1:0] pin_sync
);
    reg [WIDTH-1:0] meta_reg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= {WIDTH{1'b0}};
            pin_sync <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= pin_async;
            pin_sync <= meta_reg;
        end
    end
endmodule

/* gcu_pin_setup_properties.sv */
// Checker for the pin setup block, bound to its ports.
// Assumes the bench holds pin levels for several cycles per edge.
`timescale 1ns/10ps
`include "gcu_map.vh"
module gcu_pin_setup_properties (
    // Clock and reset
    input wire                   core_clk,
    input wire                   reset_n,
    // Register port
    input wire [`GCU_ADDR_W-1:0] reg_addr,
    input wire                   reg_rd,
    input wire [15:0]            reg_rdata,
    // Pins and events
    input wire [6:0]             pin_in,
    input wire [6:0]             pin_out,
    input wire [6:0]             pin_oe,
    input wire                   sleep_mode,
    input wire                   conv_start,
    input wire                   wake_req,
    input wire                   fault_pin
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_drv; (pin_out & ~pin_oe) == 7'h00; endproperty
    a_drv: assert property (p_drv) else $error("level on idle pin");
    property p_rda; $past(reg_rd) && $past(reg_addr) == 8'h1D
        |-> reg_rdata[15:14] == 2'h0; endproperty
    a_rda: assert property (p_rda) else $error("setup A top bits");
    property p_rdb; $past(reg_rd) && $past(reg_addr) == 8'h1E
        |-> reg_rdata[15:10] == 6'h00; endproperty
    a_rdb: assert property (p_rdb) else $error("setup B top bits");
    property p_rst; $rose(reset_n) |-> pin_oe == 7'h00; endproperty
    a_rst: assert property (p_rst) else $error("driven after reset");
    property p_cv; conv_start |-> $past(pin_in[2], 3); endproperty
    a_cv: assert property (p_cv) else $error("start without high pin");
    property p_cvp; conv_start |=> !conv_start; endproperty
    a_cvp: assert property (p_cvp) else $error("start too long");
    property p_wk; wake_req |-> $past(sleep_mode); endproperty
    a_wk: assert property (p_wk) else $error("wake while awake");
    property p_ft; fault_pin |-> $past(pin_in[0], 3)
        || $past(pin_in[0], 4); endproperty
    a_ft: assert property (p_ft) else $error("fault with low pin");
    c_cv: cover property (conv_start);
    c_wk: cover property (wake_req);
    c_ft: cover property (fault_pin);
endmodule
bind gcu_pin_setup gcu_pin_setup_properties u_props (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .sleep_mode(sleep_mode), .conv_start(conv_start),
    .wake_req(wake_req), .fault_pin(fault_pin));

/* gcu_pin_world.sv */
// Model of the outside world on the seven pins.
// Assumes the bench sets the outside level of every pin.
`timescale 1ns/10ps
module gcu_pin_world (
    // Block side
    input  wire [6:0] pin_out,
    input  wire [6:0] pin_oe,
    // Bench side
    input  wire [6:0] ext_level,
    output wire [6:0] pin_in
);
    // A driven pin shows the block's level, else the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* tb_gcu_pin_setup.sv */
// Bench for the pin setup block with the pin world model.
// Assumes a 10 MHz clock and read data one cycle after the strobe.
`timescale 1ns/10ps
`include "gcu_map.vh"
module tb_gcu_pin_setup;
    reg         core_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         normal_mode = 1'b0;
    reg         sleep_mode = 1'b0;
    reg  [6:0]  ext_level = 7'h00;
    wire [15:0] reg_rdata;
    wire [6:0]  pin_in, pin_out, pin_oe;
    wire        conv_start, wake_req, fault_pin, irq;
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     m, n;
    always #50 core_clk = ~core_clk;
    gcu_pin_setup DUT (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .normal_mode(normal_mode),
        .sleep_mode(sleep_mode), .conv_start(conv_start),
        .wake_req(wake_req), .fault_pin(fault_pin), .irq(irq));
    gcu_pin_world u_world (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .pin_in(pin_in));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask
    task rd(input [7:0] a, input [15:0] exp);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, exp);
        end
    endtask
    // Counts event pulses over a rise and a fall of one pin.
    task pulses(input integer p, input integer exp);
        begin
            n = 0;
            ext_level[p] <= 1'b1;
            repeat (8) @(negedge core_clk) n = n + (p ? conv_start : wake_req);
            @(posedge core_clk);
            ext_level[p] <= 1'b0;
            repeat (8) @(negedge core_clk) n = n + (p ? conv_start : wake_req);
            @(posedge core_clk);
            chk(n, exp);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #100000 bad_count = bad_count + 1;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`GCU_PIN_SETUP_A, 16'h0000);
        rd(`GCU_PIN_SETUP_B, 16'h0000);
        wr(`GCU_PIN_SETUP_A, 16'hFFFF);
        rd(`GCU_PIN_SETUP_A, 16'h3FFF);
        wr(`GCU_PIN_SETUP_B, 16'hFFD5);
        rd(`GCU_PIN_SETUP_B, 16'h03D5);
        rd(8'h40, 16'h0000);
        chk(pin_oe, 16'h007F);
        chk(pin_out, 16'h0055);
        rd(`GCU_PIN_LEVEL, 16'h0055);
        for (m = 0; m < 3; m = m + 1) begin
            wr(`GCU_PIN_SETUP_A, {2'b00, {7{m[1:0]}}});
            chk(pin_oe, 16'h0000);
            chk(pin_out, 16'h0000);
        end
        $display("test registers and modes done");
        wr(`GCU_PIN_SETUP_A, 16'h0020);
        normal_mode <= 1'b1;
        pulses(2, 1);
        rd(`GCU_IRQ_STATUS, 16'h0001);
        chk(irq, 16'h0000);
        wr(`GCU_IRQ_MASK, 16'h0001);
        rd(`GCU_IRQ_MASK, 16'h0001);
        chk(irq, 16'h0001);
        wr(`GCU_IRQ_STATUS, 16'h0001);
        chk(irq, 16'h0000);
        normal_mode <= 1'b0;
        pulses(2, 0);
        wr(`GCU_PIN_SETUP_A, 16'h0000);
        normal_mode <= 1'b1;
        pulses(2, 0);
        $display("test trigger and interrupt done");
        sleep_mode <= 1'b1;
        pulses(0, 0);
        wr(`GCU_PIN_SETUP_A, 16'h0002);
        pulses(0, 2);
        rd(`GCU_IRQ_STATUS, 16'h0006);
        wr(`GCU_IRQ_STATUS, 16'h0006);
        rd(`GCU_IRQ_STATUS, 16'h0000);
        wr(`GCU_PIN_SETUP_B, 16'h0080);
        pulses(0, 0);
        ext_level[0] <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk(fault_pin, 16'h0001);
        wr(`GCU_PIN_SETUP_A, 16'h0000);
        repeat (2) @(posedge core_clk);
        chk(fault_pin, 16'h0000);
        $display("test wake and fault done");
        wrap_up;
    end
endmodule
